// ### verification/sdil_core_assertions.sv
// Port assertions for the serial converter input logic
`timescale 1ns/1ns
`default_nettype none
module sdil_core_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clear_n_i,
    input wire logic load_low_a_i,
    input wire logic load_low_b_i,
    input wire logic [11:0] hold_word_o,
    input wire logic polarity_o,
    input wire logic [10:0] magnitude_o,
    input wire logic at_zero_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_POL: assert property (polarity_o == hold_word_o[11])
        else $error("polarity bit differs from word");
    AST_MAG: assert property (magnitude_o == hold_word_o[10:0])
        else $error("magnitude differs from word");
    AST_ZERO: assert property (at_zero_o == (hold_word_o == 12'h800))
        else $error("zero flag differs from word");
    AST_CLR: assert property (!clear_n_i |-> hold_word_o == 12'h000)
        else $error("clear did not zero word");
    AST_CLR_LDA: assert property ((!clear_n_i && !load_low_a_i)[*4]
        |=> hold_word_o == 12'h000) else $error("load beat clear");
    AST_CLR_LDB: assert property ((!clear_n_i && !load_low_b_i)[*4]
        |=> hold_word_o == 12'h000) else $error("load beat clear");
    AST_KEEP_A: assert property ((clear_n_i && load_low_a_i)[*6]
        |-> $stable(hold_word_o)) else $error("word moved");
    AST_KEEP_B: assert property ((clear_n_i && load_low_b_i)[*6]
        |-> $stable(hold_word_o)) else $error("word moved");
    AST_CLR_END: assert property ($rose(clear_n_i) |->
        hold_word_o == 12'h000 [*2]) else $error("word back after clear");
endmodule
bind sdil_core sdil_core_assertions sdil_core_assertions_i (.*);
`default_nettype wire

// ### verification/sdil_host_model.sv
// Host controller model driving serial data and the four strobes
`timescale 1ns/1ns
`default_nettype none
module sdil_host_model (
    input wire logic link_clk_i,
    output var logic serial_data_o = 1'h0,
    output var logic [3:0] strobe_o = 4'h4
);
    // Bit 11 first; data steady for four link cycles before each edge
    task send(input logic [11:0] w, input int s);
        for (int i = 11; i >= 0; i--)
        begin
            serial_data_o = w[i];
            repeat (4) @(negedge link_clk_i);
            strobe_o[s] = ~strobe_o[s];
            repeat (8) @(negedge link_clk_i);
            strobe_o[s] = ~strobe_o[s];
        end
        repeat (4) @(negedge link_clk_i);
        serial_data_o = ~serial_data_o; // No stale bit once released
    endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the serial converter input logic
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic ref_clk_i = 1'h0, link_clk_i = 1'h0, rst_b_i = 1'h0, serial_data_i;
    logic load_low_a_i = 1'h1, load_low_b_i = 1'h1, clear_n_i = 1'h1;
    logic [3:0] stb;
    logic [11:0] hold_word_o;
    logic at_zero;
    int failures = 0, num_checks = 0;
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // Link clock with a phase of its own
    initial
    begin
        #3 link_clk_i = 1'h1;
        forever #32 link_clk_i = ~link_clk_i;
    end
    sdil_core sdil_core_i (.*, .strobe_rise_a_i(stb[0]),
        .strobe_rise_b_i(stb[1]), .strobe_fall_i(stb[2]),
        .strobe_rise_c_i(stb[3]), .magnitude_o(), .polarity_o(),
        .at_zero_o(at_zero));
    sdil_host_model host_i (.link_clk_i(link_clk_i),
        .serial_data_o(serial_data_i), .strobe_o(stb));
    task check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value hold_word expected %h seen %h", exp, seen);
        end
    endtask
    // Load pulse long enough for the synchronisers, then compare
    task t_load(input logic a, input logic b, input logic [11:0] exp);
        @(negedge ref_clk_i);
        {load_low_a_i, load_low_b_i} = {a, b};
        repeat (30) @(negedge ref_clk_i);
        {load_low_a_i, load_low_b_i} = 2'h3;
        repeat (8) @(negedge ref_clk_i);
        check(hold_word_o, exp);
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #300000 failures++;
        report_and_stop;
    end
    task t_strobes;
        logic [11:0] w [4] = '{12'hA5C, 12'h3E1, 12'hFFF, 12'h800};
        for (int s = 0; s < 4; s++)
        begin
            host_i.send(w[s], s);
            t_load(1'h0, 1'h0, w[s]);
        end
        check({11'h000, at_zero}, 12'h001);
    endtask
    // A strobe held active blocks the others; one load low is no load
    task t_blocked;
        // Let the released data bit settle before this edge samples it
        repeat (4) @(negedge link_clk_i);
        host_i.strobe_o[3] = 1'h1;
        repeat (4) @(negedge link_clk_i);
        host_i.send(12'h000, 0);
        host_i.strobe_o[3] = 1'h0;
        t_load(1'h0, 1'h1, 12'h800);
        t_load(1'h1, 1'h0, 12'h800);
        t_load(1'h0, 1'h0, 12'h001);
    endtask
    task t_clear;
        clear_n_i = 1'h0;
        t_load(1'h0, 1'h0, 12'h000);
        clear_n_i = 1'h1;
        t_load(1'h0, 1'h0, 12'h001);
        {load_low_a_i, load_low_b_i} = 2'h0;
        host_i.send(12'h5B7, 1);
        @(negedge ref_clk_i);
        check(hold_word_o, 12'h5B7);
        {load_low_a_i, load_low_b_i} = 2'h3;
    endtask
    initial
    begin
        repeat (16) @(negedge ref_clk_i);
        rst_b_i = 1'h1;
        repeat (8) @(negedge link_clk_i);
        t_strobes;
        t_blocked;
        t_clear;
        report_and_stop;
    end
endmodule
`default_nettype wire

// ### verilog/sdil_core.sv
// Serial converter input logic: shift register, holding register, clear
//
// Overview of operation
// (R1) A 12-bit shift register takes the serial data level per strobe edge.
// (R2) Words arrive most significant bit first; host sends bit 11 first.
// (R3) Strobes rise_a, rise_b and rise_c shift on their rising edge.
// (R4) The falling strobe shifts on its high-to-low edge.
// (R5) A shift needs all other strobes at their inactive levels.
// (R6) Any other strobe active holds the shift register unchanged.
// (R7) Both loads low copy the shift register into the holding register.
// (R8) Either load high keeps the holding register value.
// (R9) Clear low zeroes the holding register output at once.
// (R10) Clear never touches the shift register.
// (R11) Clear low wins over any load request.
// (R12) Top held bit gives polarity, lower eleven give magnitude.
// (R13) Inputs are synchronised, though raw clear also gates the output; edges found from registered samples.
// (R14) Load held low keeps copying, following shifts in that interval.
`timescale 1ns/1ns
`default_nettype none
module sdil_core
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire logic serial_data_i,
    input wire logic strobe_rise_a_i,
    input wire logic strobe_rise_b_i,
    input wire logic strobe_fall_i,
    input wire logic strobe_rise_c_i,
    input wire logic load_low_a_i,
    input wire logic load_low_b_i,
    input wire logic clear_n_i,
    output logic [sdil_pkg::SDIL_WIDTH-1:0] hold_word_o,
    output logic polarity_o,
    output logic [sdil_pkg::SDIL_WIDTH-2:0] magnitude_o,
    output logic at_zero_o
);
    import sdil_pkg::*;

    // Link-domain reset, held by a two-stage synchroniser of the core reset
    logic [1:0] lrst_sync_reg;
    logic link_rst_b;
    // Link-domain synchronisers: data and four strobes
    logic [4:0] lsync0_reg;
    logic [4:0] lsync1_reg;
    logic [4:0] lprev_reg;
    logic [4:0] lnow;
    logic shift_go;
    logic [SDIL_WIDTH-1:0] shift_reg;
    logic [SDIL_WIDTH-1:0] shift_next;
    // Word crossing: toggle handshake back to the core clock
    logic [SDIL_WIDTH-1:0] xfer_word_reg;
    logic xfer_tgl_reg;
    logic [2:0] tgl_sync_reg;
    logic [SDIL_WIDTH-1:0] core_shift_reg;
    // Core-domain synchronisers for loads and clear
    logic [2:0] csync0_reg;
    logic [2:0] csync1_reg;
    logic load_req;
    logic clear_act;
    logic [SDIL_WIDTH-1:0] hold_reg;
    logic [SDIL_WIDTH-1:0] hold_next;

    // Reset crossing into the link clock; no edges assumed outside frames
    always_ff @(posedge link_clk_i)
    begin
        lrst_sync_reg <= {lrst_sync_reg[0], rst_b_i};
    end
    assign link_rst_b = lrst_sync_reg[1];

    // Two flip-flops before any strobe or data logic reads the pins
    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_b)
        begin
            lsync0_reg <= SDIL_LINK_IDLE;
            lsync1_reg <= SDIL_LINK_IDLE;
            lprev_reg <= SDIL_LINK_IDLE;
        end
        else
        begin
            lsync0_reg <= {serial_data_i, strobe_rise_c_i, strobe_fall_i,
                strobe_rise_b_i, strobe_rise_a_i}; // R13
            lsync1_reg <= lsync0_reg;
            lprev_reg <= lsync1_reg; // R13
        end
    end
    // Bit order: [3]=rise_c [2]=fall [1]=rise_b [0]=rise_a
    assign lnow = lsync1_reg;

    // One qualified edge with the rest idle; idle pins read as 5'h04
    always_comb
    begin
        shift_go = 1'b0;
        // Rising-edge strobes, others idle
        if (lnow[0] && !lprev_reg[0] && lnow[1] == SDIL_RISE_IDLE
            && lnow[2] == SDIL_FALL_IDLE && lnow[3] == SDIL_RISE_IDLE)
            shift_go = 1'b1; // R3 R5
        if (lnow[1] && !lprev_reg[1] && lnow[0] == SDIL_RISE_IDLE
            && lnow[2] == SDIL_FALL_IDLE && lnow[3] == SDIL_RISE_IDLE)
            shift_go = 1'b1; // R3 R5
        if (lnow[3] && !lprev_reg[3] && lnow[0] == SDIL_RISE_IDLE
            && lnow[1] == SDIL_RISE_IDLE && lnow[2] == SDIL_FALL_IDLE)
            shift_go = 1'b1; // R3 R5
        // Falling strobe uses its high-to-low edge
        if (!lnow[2] && lprev_reg[2] && lnow[0] == SDIL_RISE_IDLE
            && lnow[1] == SDIL_RISE_IDLE && lnow[3] == SDIL_RISE_IDLE)
            shift_go = 1'b1; // R4 R5
    end

    // Shift in MSB first: older bits move toward bit 11
    always_comb
    begin
        shift_next = shift_reg; // R6
        if (shift_go)
            shift_next = {shift_reg[SDIL_WIDTH-2:0], lprev_reg[4]}; // R1 R2
    end

    // Shift register lives in the link domain; clear does not reach it
    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_b)
            shift_reg <= SDIL_SHIFT_RST;
        else
            shift_reg <= shift_next; // R1 R10 R13
    end

    // Publish each new word with a toggle; word and toggle update on the same link edge
    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_b)
        begin
            xfer_word_reg <= SDIL_SHIFT_RST;
            xfer_tgl_reg <= 1'b0;
        end
        else if (xfer_word_reg != shift_reg)
        begin
            xfer_word_reg <= shift_reg;
            xfer_tgl_reg <= ~xfer_tgl_reg;
        end
    end

    // Toggle sync; word sampled only after the toggle has settled
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            tgl_sync_reg <= 3'h0;
            core_shift_reg <= SDIL_SHIFT_RST;
        end
        else
        begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], xfer_tgl_reg};
            if (tgl_sync_reg[2] != tgl_sync_reg[1])
                core_shift_reg <= xfer_word_reg;
        end
    end

    // Loads and clear pass two flip-flops; order {clear, load_b, load_a}
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            csync0_reg <= 3'h7;
            csync1_reg <= 3'h7;
        end
        else
        begin
            csync0_reg <= {clear_n_i, load_low_b_i, load_low_a_i}; // R13
            csync1_reg <= csync0_reg;
        end
    end
    assign load_req = !csync1_reg[0] && !csync1_reg[1]; // R7 R8
    // Register path uses the synchronised clear only; the raw pin would
    // reach a flip-flop input asynchronously and risk metastability
    assign clear_act = !csync1_reg[2]; // R9

    // Holding register next value: clear first, then level load
    always_comb
    begin
        hold_next = hold_reg; // R8
        if (load_req)
            hold_next = core_shift_reg; // R7 R14
        if (clear_act)
            hold_next = SDIL_HOLD_RST; // R9 R11
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            hold_reg <= SDIL_HOLD_RST;
        else
            hold_reg <= hold_next;
    end

    // Output view; asynchronous clear forces zero without waiting
    assign hold_word_o = clear_n_i ? hold_reg : SDIL_HOLD_RST; // R9 R11
    assign polarity_o = hold_word_o[SDIL_POL_BIT]; // R12
    assign magnitude_o = hold_word_o[SDIL_POL_BIT-1:0]; // R12
    assign at_zero_o = (hold_word_o == SDIL_BIPOLAR_ZERO); // R12
endmodule
`default_nettype wire

// ### verilog/sdil_pkg.sv
// Constants shared by the serial converter input logic
package sdil_pkg;
    // Word width of the shift and holding registers
    localparam int SDIL_WIDTH = 12;
    localparam logic [11:0] SDIL_HOLD_RST = 12'h000;
    localparam logic [11:0] SDIL_SHIFT_RST = 12'h000;
    // Offset-binary zero code and polarity bit position
    localparam logic [11:0] SDIL_BIPOLAR_ZERO = 12'h800;
    localparam int SDIL_POL_BIT = 11;
    // Inactive strobe levels
    localparam logic SDIL_RISE_IDLE = 1'h0;
    localparam logic SDIL_FALL_IDLE = 1'h1;
    // Idle link sample {data, rise_c, fall, rise_b, rise_a}
    localparam logic [4:0] SDIL_LINK_IDLE = 5'h04;
    // Synchroniser depth
    localparam int SDIL_SYNC_STAGES = 2;
endpackage
